// >>> src/vpfs_pkg.sv
// Package for the video port format and sync block: format codes,
// picture limits, line geometry and timing code words.
// Assumes a 10-bit data lane with codes left-justified as usual.
package vpfs_pkg;
  localparam logic [3:0] FMT_EMBED = 4'h0;
  localparam logic [3:0] FMT_MUX = 4'h2;
  localparam logic [3:0] FMT_DUAL = 4'h3;
  localparam logic [3:0] FMT_GRAY = 4'h8;

  localparam logic [9:0] MAX_H_STD = 10'd720;
  localparam logic [9:0] MAX_H_SQ525 = 10'd640;
  localparam logic [9:0] MAX_H_SQ625 = 10'd768;
  localparam logic [9:0] MAX_V_525 = 10'd243;
  localparam logic [9:0] MAX_V_625 = 10'd288;

  // Total words per line, with active words twice the sample count
  localparam logic [10:0] LINE_WORDS_525 = 11'd1716;
  localparam logic [10:0] LINE_WORDS_625 = 11'd1728;
  localparam logic [10:0] LINE_WORDS_SQ525 = 11'd1560;
  localparam logic [10:0] LINE_WORDS_SQ625 = 11'd1888;
  localparam logic [9:0] FIELD0_LINES_525 = 10'd262;
  localparam logic [9:0] FIELD0_LINES_625 = 10'd312;

  localparam logic [10:0] CODE_LEN = 11'd4;
  localparam logic [9:0] CODE_PREAMBLE = 10'h3ff;
  localparam logic [9:0] BLANK_Y = 10'h040;
  localparam logic [9:0] CHROMA_OFFSET = 10'h200;

  localparam logic [19:0] MASK_LANE10 = 20'h003ff;
  localparam logic [19:0] MASK_LANE12 = 20'h00fff;
  localparam logic [19:0] MASK_LANE20 = 20'hfffff;
endpackage

// >>> src/vpfs_tim_if.sv
// Carrier between the port logic and its line/field timing generator.
// Assumes both ends run on the one video clock.
`timescale 1ns/1ps
`default_nettype none
interface vpfs_tim_if;
  logic std625;
  logic squarePixel;
  logic [10:0] hCount;
  logic [10:0] activeWords;
  logic [10:0] lineWords;
  logic [9:0] lineInField;
  logic field;
  logic hBlank;
  logic vBlank;
  logic lineStart;
  logic fieldStart;
  modport gen (input std625, squarePixel, output hCount, activeWords, lineWords,
    lineInField, field, hBlank, vBlank, lineStart, fieldStart);
  modport user (output std625, squarePixel, input hCount, activeWords, lineWords,
    lineInField, field, hBlank, vBlank, lineStart, fieldStart);
endinterface
`default_nettype wire

// >>> src/vpfs_timing.sv
// Line and field timing generator used when the port is master, except in embedded encode.
// Assumes the standard and square-pixel controls are quasi-static.
`timescale 1ns/1ps
`default_nettype none
module vpfs_timing
  import vpfs_pkg::*;
(
  input wire logic clk, // Video clock
  input wire logic reset_n, // Synchronous reset, active low
  vpfs_tim_if.gen tif // Timing toward the port logic
);
  typedef struct packed {
    logic [10:0] hCount;
    logic [9:0] line;
    logic field;
  } vpfs_tim_state_t;

  vpfs_tim_state_t s;
  vpfs_tim_state_t n;
  logic [10:0] lineWords;
  logic [10:0] actWords;
  logic [9:0] fieldLines;
  logic [9:0] maxV;

  always_comb
  begin
    n = s;
    // Geometry follows the line standard
    if (tif.squarePixel)
      lineWords = tif.std625 ? LINE_WORDS_SQ625 : LINE_WORDS_SQ525;
    else
      lineWords = tif.std625 ? LINE_WORDS_625 : LINE_WORDS_525;
    if (tif.squarePixel)
      actWords = {tif.std625 ? MAX_H_SQ625 : MAX_H_SQ525, 1'b0};
    else
      actWords = {MAX_H_STD, 1'b0};
    fieldLines = (tif.std625 ? FIELD0_LINES_625 : FIELD0_LINES_525) + {9'h0, s.field};
    maxV = tif.std625 ? MAX_V_625 : MAX_V_525;
    if (s.hCount >= lineWords - 11'd1)
    begin
      n.hCount = 11'h000;
      if (s.line >= fieldLines - 10'd1)
      begin
        n.line = 10'h000;
        n.field = ~s.field;
      end
      else
        n.line = s.line + 10'd1;
    end
    else
      n.hCount = s.hCount + 11'd1;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  assign tif.hCount = s.hCount;
  assign tif.activeWords = actWords;
  assign tif.lineWords = lineWords;
  assign tif.lineInField = s.line;
  assign tif.field = s.field;
  assign tif.hBlank = (s.hCount >= actWords);
  // Vertical blanking leads the field so the active lines end it
  assign tif.vBlank = (s.line < fieldLines - maxV);
  assign tif.lineStart = (s.hCount == 11'h000);
  assign tif.fieldStart = (s.hCount == 11'h000) && (s.line == 10'h000);
endmodule
`default_nettype wire

// >>> src/vpfs_port.sv
// Video port: format decode, pin mapping, sync pin direction and
// timing codes for a codec's component digital video interface.
// Assumes pixel data are synchronous to clk; sync pins are resynchronised.
`timescale 1ns/1ps
`default_nettype none
module vpfs_port
  import vpfs_pkg::*;
(
  input wire logic clk, // Video sample clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic encodeMode, // 1 = receive video, 0 = drive video
  input wire logic masterMode, // 1 = generate sync signals
  input wire logic std625, // 1 = 625 lines, 0 = 525 lines
  input wire logic squarePixel, // Square pixel sampling
  input wire logic bipolarChroma, // 1 = signed chroma, 0 = offset chroma
  input wire logic [3:0] formatCode, // Video format code
  input wire logic [9:0] activeHBegin, // First active sample
  input wire logic [9:0] activeHFinish, // Last active sample
  input wire logic [9:0] activeVBegin, // First active line
  input wire logic [9:0] activeVFinish, // Last active line
  input wire logic [19:0] videoPixelBusIn, // Data pins, input side
  output logic [19:0] videoPixelBusOut, // Data pins, output side
  output logic [19:0] videoPixelBusOe, // Data pin enables
  input wire logic hsyncIn, // Horizontal sync pin in
  output logic hsyncOut, // Horizontal sync pin out
  output logic hsyncOe, // Horizontal sync enable
  input wire logic vsyncIn, // Vertical sync pin in
  output logic vsyncOut, // Vertical sync pin out
  output logic vsyncOe, // Vertical sync enable
  input wire logic fieldIn, // Field pin in
  output logic fieldOut, // Field pin out
  output logic fieldOe, // Field pin enable
  input wire logic chromaReferenceIn, // Chroma reference in
  output logic chromaReferenceOut, // Chroma reference out
  output logic chromaReferenceOe, // Chroma reference enable
  output logic directionIndicator, // High while encoding
  input wire logic [15:0] dispY, // Internal luma to send
  input wire logic [15:0] dispC, // Internal signed chroma to send
  output logic sampleReq, // Pulse: dispY/dispC consumed
  output logic [15:0] capY, // Captured luma
  output logic [15:0] capC, // Captured signed chroma
  output logic capValid, // Pulse: capture sample valid
  output logic capActive, // Capture sample inside window
  output logic codeError // Pulse: timing code failed protection
);
  typedef struct packed {
    logic [2:0] syncH;
    logic [2:0] syncV;
    logic [2:0] syncF;
    logic [2:0] syncC;
    logic pinH;
    logic pinV;
    logic pinF;
    logic pinC;
    logic prevH;
    logic prevV;
    logic [19:0] pixIn;
    logic [1:0] pre;
    logic rxH;
    logic rxV;
    logic rxF;
    logic [10:0] hPos;
    logic [9:0] line;
    logic [9:0] tmpC;
    logic [15:0] capY;
    logic [15:0] capC;
    logic capValid;
    logic capActive;
    logic codeError;
    logic [19:0] dOut;
    logic [19:0] dOe;
    logic hOut;
    logic vOut;
    logic fOut;
    logic cOut;
    logic syncOe;
    logic dir;
    logic sampleReq;
  } vpfs_port_state_t;

  vpfs_tim_if tif ();
  vpfs_port_state_t s;
  vpfs_port_state_t n;
  logic fmtEmbed;
  logic fmtDual;
  logic fmtGray;
  logic fmtOk;
  logic useGen;
  logic xyOk;
  logic lineEv;
  logic fieldEv;
  logic [10:0] curH;
  logic [9:0] curL;
  logic [9:0] maxH;
  logic [9:0] maxV;
  logic inWin;
  logic chromaPh;
  logic eavSlot;
  logic savSlot;
  logic [1:0] codeIdx;
  logic [9:0] blankC;
  logic [9:0] sendC;

  assign tif.std625 = std625;
  assign tif.squarePixel = squarePixel;

  vpfs_timing u_timing (
    .clk(clk),
    .reset_n(reset_n),
    .tif(tif)
  );

  function automatic logic [9:0] xyWord(input logic f, input logic v, input logic h);
    xyWord = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
  endfunction

  function automatic logic [15:0] chromaIn(input logic [9:0] c, input logic bip);
    // Unipolar removes the offset so the kernel always sees signed chroma
    chromaIn = {bip ? c : c - CHROMA_OFFSET, 6'h00};
  endfunction

  always_comb
  begin
    n = s;
    fmtEmbed = (formatCode == FMT_EMBED);
    fmtDual = (formatCode == FMT_DUAL);
    fmtGray = (formatCode == FMT_GRAY);
    fmtOk = fmtEmbed || fmtDual || fmtGray || (formatCode == FMT_MUX);
    // Embedded encode follows received codes, even as master
    useGen = masterMode && !(fmtEmbed && encodeMode);
    xyOk = 1'b0;
    lineEv = 1'b0;
    fieldEv = 1'b0;
    // Three-stage resync; a change counts once stages two and three agree
    n.syncH = {s.syncH[1:0], hsyncIn};
    n.syncV = {s.syncV[1:0], vsyncIn};
    n.syncF = {s.syncF[1:0], fieldIn};
    n.syncC = {s.syncC[1:0], chromaReferenceIn};
    if (s.syncH[1] == s.syncH[2])
      n.pinH = s.syncH[2];
    if (s.syncV[1] == s.syncV[2])
      n.pinV = s.syncV[2];
    if (s.syncF[1] == s.syncF[2])
      n.pinF = s.syncF[2];
    if (s.syncC[1] == s.syncC[2])
      n.pinC = s.syncC[2];
    n.prevH = s.pinH;
    n.prevV = s.pinV;
    n.pixIn = videoPixelBusIn;

    // Timing code search: preamble 3ff 000 000, then the flag word
    n.pre = 2'd0;
    n.codeError = 1'b0;
    if (s.pre == 2'd3)
    begin
      xyOk = (s.pixIn[9:0] == xyWord(s.pixIn[8], s.pixIn[7], s.pixIn[6]));
      n.codeError = !xyOk && fmtEmbed && encodeMode;
    end
    else if (s.pixIn[9:0] == CODE_PREAMBLE)
      n.pre = 2'd1;
    else if (s.pre != 2'd0 && s.pixIn[9:0] == 10'h000)
      n.pre = s.pre + 2'd1;
    if (xyOk)
    begin
      n.rxF = s.pixIn[8];
      n.rxV = s.pixIn[7];
      n.rxH = s.pixIn[6];
    end

    // Slave embedded is undefined; it is handled like master encode
    if (fmtEmbed)
    begin
      lineEv = xyOk && !s.pixIn[6];
      fieldEv = lineEv && s.rxV && !s.pixIn[7];
    end
    else
    begin
      lineEv = s.pinH && !s.prevH;
      fieldEv = s.pinV && !s.prevV;
    end
    if (lineEv)
      n.hPos = 11'h000;
    else if (s.hPos != 11'h7ff)
      n.hPos = s.hPos + 11'd1;
    if (fieldEv)
      n.line = 10'h000;
    else if (lineEv && s.line != 10'h3ff)
      n.line = s.line + 10'd1;

    curH = useGen ? tif.hCount : s.hPos;
    curL = useGen ? tif.lineInField : s.line;
    if (squarePixel)
      maxH = std625 ? MAX_H_SQ625 : MAX_H_SQ525;
    else
      maxH = MAX_H_STD;
    maxV = std625 ? MAX_V_625 : MAX_V_525;
    // Window clipped to the standard's picture size
    inWin = (curH[10:1] >= activeHBegin) && (curH[10:1] <= activeHFinish)
      && (curH[10:1] < maxH) && (curL >= activeVBegin)
      && (curL <= activeVFinish) && (curL < maxV);
    // In slave pin formats the chroma reference pin sets word phase
    chromaPh = (!masterMode && !fmtEmbed) ? s.pinC : !curH[0];

    // Capture toward the internal 4:2:2 path
    n.capValid = 1'b0;
    // Window flag is only meaningful alongside its sample
    n.capActive = 1'b0;
    if (encodeMode && fmtOk && !chromaPh)
    begin
      n.capValid = 1'b1;
      n.capActive = inWin;
      if (fmtDual)
      begin
        n.capY = {s.pixIn[9:0], 6'h00};
        n.capC = chromaIn(s.pixIn[19:10], bipolarChroma);
      end
      else if (fmtGray)
      begin
        n.capY = {s.pixIn[11:0], 4'h0};
        n.capC = 16'h0000;
      end
      else
      begin
        n.capY = {s.pixIn[9:0], 6'h00};
        n.capC = chromaIn(s.tmpC, bipolarChroma);
      end
    end
    if (encodeMode && chromaPh)
      n.tmpC = s.pixIn[9:0];

    // Drive side
    eavSlot = (tif.hCount >= tif.activeWords) && (tif.hCount < tif.activeWords + CODE_LEN);
    savSlot = (tif.hCount >= tif.lineWords - CODE_LEN);
    if (eavSlot)
      codeIdx = 2'(tif.hCount - tif.activeWords);
    else
      codeIdx = 2'(tif.hCount - (tif.lineWords - CODE_LEN));
    blankC = bipolarChroma ? 10'h000 : CHROMA_OFFSET;
    sendC = bipolarChroma ? dispC[15:6] : dispC[15:6] + CHROMA_OFFSET;
    n.sampleReq = 1'b0;
    n.dOut = 20'h00000;
    if (fmtEmbed && useGen && (eavSlot || savSlot))
    begin
      // Codes placed by the generator's 525/625 geometry
      if (codeIdx == 2'd0)
        n.dOut = {10'h000, CODE_PREAMBLE};
      else if (codeIdx == 2'd3)
        n.dOut = {10'h000, xyWord(tif.field, tif.vBlank, eavSlot)};
    end
    else if (fmtDual)
    begin
      n.dOut = inWin ? {sendC, dispY[15:6]} : {blankC, BLANK_Y};
      n.sampleReq = inWin && !encodeMode && !chromaPh;
    end
    else if (fmtGray)
    begin
      n.dOut = inWin ? {8'h00, dispY[15:4]} : {8'h00, BLANK_Y, 2'b00};
      n.sampleReq = inWin && !encodeMode && !chromaPh;
    end
    else
    begin
      if (inWin)
        n.dOut = {10'h000, chromaPh ? sendC : dispY[15:6]};
      else
        n.dOut = {10'h000, chromaPh ? blankC : BLANK_Y};
      n.sampleReq = inWin && !encodeMode && !chromaPh;
    end
    if (!encodeMode && fmtOk)
      n.dOe = fmtDual ? MASK_LANE20 : (fmtGray ? MASK_LANE12 : MASK_LANE10);
    else
      n.dOe = 20'h00000;

    // Sync pin direction and level
    n.syncOe = masterMode;
    if (fmtEmbed && encodeMode)
    begin
      n.hOut = s.rxH;
      n.vOut = s.rxV;
      n.fOut = s.rxF;
    end
    else
    begin
      n.hOut = tif.hBlank;
      n.vOut = tif.vBlank;
      n.fOut = tif.field;
    end
    n.cOut = chromaPh;
    n.dir = encodeMode;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= n;
  end

  assign videoPixelBusOut = s.dOut;
  assign videoPixelBusOe = s.dOe;
  assign hsyncOut = s.hOut;
  assign hsyncOe = s.syncOe;
  assign vsyncOut = s.vOut;
  assign vsyncOe = s.syncOe;
  assign fieldOut = s.fOut;
  assign fieldOe = s.syncOe;
  assign chromaReferenceOut = s.cOut;
  assign chromaReferenceOe = s.syncOe;
  assign directionIndicator = s.dir;
  assign sampleReq = s.sampleReq;
  assign capY = s.capY;
  assign capC = s.capC;
  assign capValid = s.capValid;
  assign capActive = s.capActive;
  assign codeError = s.codeError;
endmodule
`default_nettype wire

// >>> tb/vpfs_port_chk.sv
// Checker for vpfs_port: pin direction, lane use and timing code shape.
// Sees only the port's pins; bound to every vpfs_port at the foot.
`timescale 1ns/1ps
`default_nettype none
module vpfs_port_chk
  import vpfs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic reset_n, // Reset
  input wire logic encodeMode, // Direction
  input wire logic masterMode, // Sync owner
  input wire logic [3:0] formatCode, // Format
  input wire logic [19:0] videoPixelBusOut, // Data out
  input wire logic [19:0] videoPixelBusOe, // Data enables
  input wire logic hsyncOe, // Enable
  input wire logic vsyncOe, // Enable
  input wire logic fieldOe, // Enable
  input wire logic chromaReferenceOe, // Enable
  input wire logic directionIndicator, // Direction pin
  input wire logic capValid, // Capture strobe
  input wire logic capActive, // In window
  input wire logic codeError // Bad code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] w;
  assign w = videoPixelBusOut[9:0];
  function automatic logic [19:0] laneMask(input logic [3:0] f);
    case (f)
      FMT_EMBED, FMT_MUX: return MASK_LANE10;
      FMT_DUAL: return MASK_LANE20;
      FMT_GRAY: return MASK_LANE12;
      default: return 20'h00000;
    endcase
  endfunction
  dir_pin_a:
    assert property ($past(reset_n) |-> directionIndicator == $past(encodeMode))
    else $error("direction pin lags control wrongly");
  sync_dir_a:
    assert property ($past(reset_n) |-> {hsyncOe, vsyncOe, fieldOe, chromaReferenceOe}
      == {4{$past(masterMode)}}) else $error("sync enables do not follow master");
  enc_quiet_a:
    assert property (encodeMode && $past(encodeMode) |-> videoPixelBusOe == 20'h00000)
    else $error("data driven while encoding");
  lane_use_a:
    assert property ($past(reset_n) && !encodeMode && $stable(encodeMode)
      && $stable(formatCode) |-> videoPixelBusOe == laneMask(formatCode))
    else $error("data enables do not match format");
  cap_enc_a:
    assert property (capValid |-> $past(encodeMode)) else $error("capture while decoding");
  cap_win_a:
    assert property (capActive |-> capValid) else $error("active flag without sample");
  code_err_a:
    assert property (codeError |-> $past(encodeMode) && $past(formatCode) == FMT_EMBED)
    else $error("code error outside embedded capture");
  code_shape_a:
    assert property (!$past(encodeMode) && formatCode == FMT_EMBED && $stable(formatCode)
      && videoPixelBusOe[0] && w == 10'h3ff |-> ##1 w == 10'h000 ##1 w == 10'h000
      ##1 (w[9] && w[1:0] == 2'h0 && w[5] == (w[7] ^ w[6]) && w[4] == (w[8] ^ w[6])
      && w[3] == (w[8] ^ w[7]) && w[2] == (w[8] ^ w[7] ^ w[6])))
    else $error("malformed timing code");
endmodule
bind vpfs_port vpfs_port_chk vpfs_port_chk_i (.clk, .reset_n, .encodeMode, .masterMode,
  .formatCode, .videoPixelBusOut, .videoPixelBusOe, .hsyncOe, .vsyncOe, .fieldOe,
  .chromaReferenceOe, .directionIndicator, .capValid, .capActive, .codeError);
`default_nettype wire

// >>> tb/vpfs_src_model.sv
// Source of embedded-code video toward the port's data pins.
// Words change on falling edges; unused upper pins sit at the pull-down level.
`timescale 1ns/1ps
`default_nettype none
module vpfs_src_model
  import vpfs_pkg::*;
(
  input wire logic clk, // Video clock
  output logic [19:0] pixelBus, // Data toward the port
  output logic hsync, // Held low, port is master
  output logic vsync, // Held low, port is master
  output logic field, // Held low, port is master
  output logic chromaRef // Held low, port is master
);
  // Slave pins stay idle: embedded format is only run with the port as master
  initial
  begin
    pixelBus = {10'h000, BLANK_Y};
    {hsync, vsync, field, chromaRef} = 4'h0;
  end
  task automatic put(input logic [9:0] v);
    @(negedge clk);
    pixelBus = {10'h000, v};
  endtask
  task automatic send_code(input logic f, input logic v, input logic h, input logic bad);
    logic [9:0] xy;
    xy = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'h0};
    // A broken word flips one protection bit only
    if (bad)
      xy[2] = ~xy[2];
    put(CODE_PREAMBLE);
    put(10'h000);
    put(10'h000);
    put(xy);
  endtask
  task automatic send_pair(input logic [9:0] c, input logic [9:0] y);
    put(c);
    put(y);
    put(BLANK_Y);
  endtask
endmodule
`default_nettype wire

// >>> tb/vpfs_port_tb.sv
// Self-checking bench for vpfs_port with a source model on the data pins.
// One 10 MHz clock; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module vpfs_port_tb;
  import vpfs_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic encodeMode = 1'b0;
  logic masterMode = 1'b1;
  logic std625 = 1'b0;
  logic squarePixel = 1'b0;
  logic bipolarChroma = 1'b0;
  logic [3:0] formatCode = FMT_MUX;
  logic [15:0] dispY = 16'h1234;
  logic [15:0] dispC = 16'h0a40;
  logic [19:0] videoPixelBusIn, videoPixelBusOut, videoPixelBusOe;
  logic hsyncIn, vsyncIn, fieldIn, chromaReferenceIn, hsyncOut, vsyncOut, fieldOut;
  logic hsyncOe, vsyncOe, fieldOe, chromaReferenceOe, directionIndicator, sampleReq;
  logic chromaReferenceOut;
  logic [9:0] activeHBegin = 10'h000;
  logic [9:0] activeHFinish = 10'h3ff;
  logic capValid, capActive, codeError;
  logic [15:0] capY, capC;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  always #50 clk = ~clk;
  vpfs_port vpfs_port_i (.clk, .reset_n, .encodeMode, .masterMode, .std625, .squarePixel,
    .bipolarChroma, .formatCode, .activeHBegin, .activeHFinish,
    .activeVBegin(10'h000), .activeVFinish(10'h3ff), .videoPixelBusIn, .videoPixelBusOut,
    .videoPixelBusOe, .hsyncIn, .hsyncOut, .hsyncOe, .vsyncIn, .vsyncOut, .vsyncOe,
    .fieldIn, .fieldOut, .fieldOe, .chromaReferenceIn, .chromaReferenceOut,
    .chromaReferenceOe, .directionIndicator, .dispY, .dispC, .sampleReq, .capY, .capC,
    .capValid, .capActive, .codeError);
  vpfs_src_model vpfs_src_model_i (.clk, .pixelBus(videoPixelBusIn), .hsync(hsyncIn),
    .vsync(vsyncIn), .field(fieldIn), .chromaRef(chromaReferenceIn));
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Covers all scenarios; the window starts at line 0, so no wait for a first active line is needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      failures++;
      $display("mismatch %0t run did not finish", $time);
      tally_and_finish();
    end
  end
  task automatic cmp20(input logic [19:0] got, input logic [19:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic t_dirs();
    for (int i = 0; i < 4; i++)
    begin
      encodeMode = i[0];
      masterMode = i[1];
      repeat (3) @(negedge clk);
      cmp20({19'h0, directionIndicator}, {19'h0, encodeMode}, "direction");
      cmp20({16'h0, hsyncOe, vsyncOe, fieldOe, chromaReferenceOe},
        {16'h0, {4{masterMode}}}, "sync direction");
      cmp20(videoPixelBusOe, encodeMode ? 20'h0 : MASK_LANE10, "data dir");
    end
  endtask
  task automatic t_lanes();
    logic [3:0] f [6] = '{FMT_EMBED, FMT_MUX, FMT_DUAL, FMT_GRAY, 4'h5, 4'hf};
    logic [19:0] m [6] = '{MASK_LANE10, MASK_LANE10, MASK_LANE20, MASK_LANE12, 20'h0, 20'h0};
    encodeMode = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      formatCode = f[i];
      repeat (3) @(negedge clk);
      cmp20(videoPixelBusOe, m[i], "lane enables");
    end
  endtask
  task automatic t_data();
    int n;
    logic [19:0] e;
    formatCode = FMT_DUAL;
    for (int i = 0; i < 3; i++)
    begin
      bipolarChroma = i[0];
      if (i == 2)
        formatCode = FMT_GRAY;
      e = (i == 2) ? {8'h00, dispY[15:4]}
        : {dispC[15:6] + (i[0] ? 10'h000 : 10'h200), dispY[15:6]};
      repeat (3) @(negedge clk);
      n = 0;
      while (sampleReq !== 1'b1 && n < 40000)
      begin
        @(negedge clk);
        n++;
      end
      cmp20(videoPixelBusOut & videoPixelBusOe, e, "pixel word");
    end
  endtask
  task automatic t_window();
    int n;
    formatCode = FMT_DUAL;
    bipolarChroma = 1'b0;
    // One sample wide window: two words per line, then blanking
    activeHBegin = 10'h010;
    activeHFinish = 10'h010;
    repeat (3) @(negedge clk);
    n = 0;
    while (sampleReq !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    cmp20(videoPixelBusOut, {dispC[15:6] + CHROMA_OFFSET, dispY[15:6]}, "window word");
    cmp20({19'h0, chromaReferenceOut}, 20'h0, "luma phase");
    @(negedge clk);
    cmp20(videoPixelBusOut, {CHROMA_OFFSET, BLANK_Y}, "blank word");
    cmp20({19'h0, chromaReferenceOut}, 20'h1, "chroma phase");
    activeHBegin = 10'h000;
    activeHFinish = 10'h3ff;
  endtask
  task automatic next_code(output logic [9:0] xy, output int at);
    int n;
    n = 0;
    while (!(videoPixelBusOe[0] === 1'b1 && videoPixelBusOut[9:0] === 10'h3ff) && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    at = cycles;
    repeat (3) @(negedge clk);
    xy = videoPixelBusOut[9:0];
    @(negedge clk);
  endtask
  task automatic t_embed_dec();
    logic [9:0] xy;
    logic [10:0] aw, lw;
    int t0, t1, t2;
    formatCode = FMT_EMBED;
    bipolarChroma = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      {std625, squarePixel} = i[1:0];
      aw = {(squarePixel ? (std625 ? MAX_H_SQ625 : MAX_H_SQ525) : MAX_H_STD), 1'b0};
      lw = squarePixel ? (std625 ? LINE_WORDS_SQ625 : LINE_WORDS_SQ525)
        : (std625 ? LINE_WORDS_625 : LINE_WORDS_525);
      next_code(xy, t0);
      next_code(xy, t0);
      if (xy[6])
        next_code(xy, t0);
      next_code(xy, t1);
      cmp20({19'h0, xy[6]}, 20'h1, "end code flag");
      cmp20(20'(t1 - t0), 20'(aw + CODE_LEN), "active span");
      @(negedge clk);
      cmp20({17'h0, fieldOut, vsyncOut, hsyncOut}, {17'h0, xy[8:6]}, "sync pins");
      next_code(xy, t2);
      cmp20({19'h0, xy[6]}, 20'h0, "start code flag");
      cmp20(20'(t2 - t1), 20'(lw - aw - CODE_LEN), "blank span");
    end
  endtask
  task automatic t_embed_enc();
    int n;
    encodeMode = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      std625 = k[0];
      vpfs_src_model_i.send_code(k[2], k[1], k[0], 1'b0);
      repeat (4) @(negedge clk);
      cmp20({17'h0, fieldOut, vsyncOut, hsyncOut}, 20'(k[2:0]), "mirrored pins");
    end
    vpfs_src_model_i.send_code(1'b0, 1'b0, 1'b1, 1'b1);
    n = 0;
    while (codeError !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    cmp20({19'h0, codeError}, 20'h1, "code error");
    vpfs_src_model_i.send_code(1'b0, 1'b0, 1'b0, 1'b0);
    vpfs_src_model_i.send_pair(10'h2a0, 10'h155);
    n = 0;
    while (capValid !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    cmp16(capY, {10'h155, 6'h00}, "luma");
    cmp16(capC, {10'h2a0 - 10'h200, 6'h00}, "chroma");
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    cmp20(videoPixelBusOe, 20'h0, "enable in reset");
    reset_n = 1'b1;
    t_dirs();
    t_lanes();
    t_data();
    t_window();
    t_embed_dec();
    t_embed_enc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
